// ---- verilog/cke_ctrl_pkg.sv ----
// Shared constants and types for the clock-enable state logic.
package cke_ctrl_pkg;

    // Clock rate and time figures.
    localparam int CLK_PERIOD_PS            = 4000;
    localparam int SR_EXIT_NON_READ_PS      = 140000;
    localparam int SR_EXIT_NON_READ_CLKS    = (SR_EXIT_NON_READ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MIN_ENABLE_LEVEL_CLKS    = 3;
    localparam int SR_EXIT_READ_CLKS        = 200;
    localparam int FREQ_CHANGE_MIN_CLKS     = 2;
    localparam int PD_EXIT_TO_CMD_CLKS      = 2;
    localparam int FAST_EXIT_READ_CLKS      = 2;
    localparam int SLOW_EXIT_READ_CLKS      = 7;
    localparam int LOAD_MODE_TO_CMD_CLKS    = 2;
    localparam int READ_BUSY_CLKS           = 7;
    localparam int WRITE_BUSY_CLKS          = 6;

    // Main mode register fields.
    localparam int MR_FAST_EXIT_BIT         = 12;
    localparam int MR_WR_LSB                = 9;
    localparam logic [13:0] MR_RESET        = 14'h0000;

    // Commands as {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] CMD_LOAD_MODE    = 4'h0;
    localparam logic [3:0] CMD_REFRESH      = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE    = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE     = 4'h3;
    localparam logic [3:0] CMD_WRITE        = 4'h4;
    localparam logic [3:0] CMD_READ         = 4'h5;
    localparam logic [3:0] CMD_NOP          = 4'h7;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL         = 8'h00;
    localparam logic [7:0] OFS_MODE         = 8'h04;
    localparam logic [7:0] OFS_STATUS       = 8'h08;
    localparam logic [7:0] OFS_FLAGS        = 8'h0c;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam int CTRL_TERM_EN_BIT         = 0;

    // Sticky flag positions.
    localparam int FLG_LEVEL_TIME           = 0;
    localparam int FLG_BAD_CKE_CMD          = 1;
    localparam int FLG_ENTRY_BUSY           = 2;
    localparam int FLG_EXIT_WINDOW          = 3;
    localparam int FLG_SR_NOT_IDLE          = 4;
    localparam int FLG_TERM_IN_SR           = 5;
    localparam int FLG_WIDTH                = 6;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_PRE_PD,
        ST_ACT_PD,
        ST_SELF_REF
    } cke_state_t;

endpackage : cke_ctrl_pkg

// ---- verilog/delay_countdown.sv ----
// Loadable down-counter that reports when a delay window has elapsed.
`timescale 1ns/100ps
module delay_countdown #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input  wire logic             core_clk_in,
    input  wire logic             srst_in,
    // Load and status.
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] value_in,
    output      logic             done_out
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    assign count_next = load_in ? value_in :
                        (count_reg != '0) ? count_reg - WIDTH'(1) : count_reg;
    assign done_out   = (count_reg == '0);

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule : delay_countdown

// ---- verilog/cke_power_ctrl.sv ----
// Clock-enable power-down and self-refresh state logic with an AHB-Lite register slave.
// Rules from the document
// R01: Clock enable must hold each new level for three registered edges.
// R02: After power-down exit, non-READ commands wait the exit-to-command delay.
// R03: READ after active power-down exit uses fast or slow delay per mode bit 12.
// R04: No power-down entry while a column access is running.
// R05: If the loop was unlocked at entry, controller resets it after exit.
// R06: Entry and exit need NOP or DESELECT; low clock enable holds power-down.
// R07: Falling clock enable enters active power-down if a row is open, else precharge.
// R08: Self refresh entered on falling clock enable with REFRESH, only when idle.
// R09: Self refresh exit by NOP; non-READ after exit delay, READ after 200 clocks.
// R10: No refresh happens in power-down; controller limits its length.
// R11: Termination pin valid in power-down; termination unavailable in self refresh.
// R12: No power-down during READ, WRITE, mode load or PRECHARGE operations.
// R13: Combinations absent from the clock-enable table are illegal.
// R14: Entry after READ no sooner than the clock after the burst ends.
// R15: Entry after WRITE waits until the write burst completes.
// R16: WRITE with auto precharge allows entry one clock after write recovery.
// R17: Write recovery field sits in mode bits 9 to 11, in whole clocks.
// R18: Entry allowed one clock after REFRESH, ACTIVATE or PRECHARGE.
// R19: Precharge power-down after a mode load waits the load-to-command delay.
// R20: Clock may change only in precharge power-down, two clocks after entry.
// R21: New clock stable one cycle before exit; loop reset and settings reloaded.
// R22: Termination stays off during the 200-cycle relock period; the code gates termination only while in self refresh.
// R23: Power-down disables buffers except clock, enable, termination; freezes loop. The code freezes the loop only in precharge power-down.
// R24: Clock enable stays high from READ or WRITE until the burst completes.
// R25: Clock enable is registered each edge; transitions use previous and current levels.
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
module cke_power_ctrl #(
    parameter int TIMER_WIDTH = 8
) (
    // Clock and reset.
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    // AHB-Lite slave.
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output      logic [31:0] hrdata_out,
    output      logic        hreadyout_out,
    output      logic        hresp_out,
    // Memory pins.
    input  wire logic        cke_in,
    input  wire logic        cs_n_in,
    input  wire logic        ras_n_in,
    input  wire logic        cas_n_in,
    input  wire logic        we_n_in,
    input  wire logic [1:0]  ba_in,
    input  wire logic [13:0] addr_in,
    input  wire logic        termination_control_in,
    // Power state outputs.
    output      logic        power_down_out,
    output      logic        self_refresh_out,
    output      logic        buffers_off_out,
    output      logic        dll_frozen_out,
    output      logic        termination_active_out,
    output      logic        cmd_ready_out,
    output      logic        read_ready_out,
    output      logic        freq_change_ok_out
);

    localparam int A_READ_MAX = 20;
    localparam int A_SR_MAX   = 210;

    // Two-flop synchronisers for every pin.
    logic [21:0] pins_s1_reg;
    logic [21:0] pins_s2_reg;
    logic        cke_prev_reg;
    always_ff @(posedge core_clk_in) begin
        pins_s1_reg <= {cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, ba_in, addr_in, termination_control_in};
        pins_s2_reg <= pins_s1_reg;
    end

    wire        cke_cur  = pins_s2_reg[21];
    wire [3:0]  cmd_raw  = pins_s2_reg[20:17];
    wire [1:0]  bank     = pins_s2_reg[16:15];
    wire [13:0] addr     = pins_s2_reg[14:1];
    wire        term_pin = pins_s2_reg[0];
    wire [3:0]  cmd      = cmd_raw[3] ? cke_ctrl_pkg::CMD_NOP : cmd_raw;
    wire        is_nop   = (cmd == cke_ctrl_pkg::CMD_NOP);
    wire        is_read  = (cmd == cke_ctrl_pkg::CMD_READ);
    wire        is_write = (cmd == cke_ctrl_pkg::CMD_WRITE);
    wire        fall     = cke_prev_reg && !cke_cur;
    wire        rise     = !cke_prev_reg && cke_cur;
    wire        both_hi  = cke_prev_reg && cke_cur;

    cke_ctrl_pkg::cke_state_t state_reg;
    cke_ctrl_pkg::cke_state_t state_next;
    logic [3:0]             banks_open_reg;
    logic [3:0]             banks_open_next;
    logic [13:0]            mode_reg;
    logic [7:0]             busy_reg;
    logic [7:0]             busy_next;
    logic                   ap_pending_reg;
    logic [1:0]             ap_bank_reg;
    logic [1:0]             level_cnt_reg;
    logic [1:0]             pd_low_cnt_reg;
    logic [31:0]            ctrl_reg;
    logic [cke_ctrl_pkg::FLG_WIDTH-1:0] flags_reg;
    logic [cke_ctrl_pkg::FLG_WIDTH-1:0] flag_set;
    logic [cke_ctrl_pkg::FLG_WIDTH-1:0] flag_clr;

    wire in_pd      = (state_reg == cke_ctrl_pkg::ST_PRE_PD) || (state_reg == cke_ctrl_pkg::ST_ACT_PD);
    wire in_sr      = (state_reg == cke_ctrl_pkg::ST_SELF_REF);
    wire in_pre_pd  = (state_reg == cke_ctrl_pkg::ST_PRE_PD);
    wire normal     = !in_pd && !in_sr;
    wire any_open   = (banks_open_reg != 4'h0);
    wire entry_ok   = (busy_reg == 8'h00);
    wire pd_exit    = in_pd && rise;
    wire sr_exit    = in_sr && rise;
    wire fast_exit  = !mode_reg[cke_ctrl_pkg::MR_FAST_EXIT_BIT];
    wire [2:0] wr_field = mode_reg[cke_ctrl_pkg::MR_WR_LSB +: 3];
    wire term_en    = ctrl_reg[cke_ctrl_pkg::CTRL_TERM_EN_BIT];
    wire exec_cmd   = normal && both_hi && !is_nop;
    wire nr_done;
    wire rd_done;

    // Exit windows: non-READ delay and READ delay after leaving a low-power state.
    wire [TIMER_WIDTH-1:0] nr_load_val = in_sr ? TIMER_WIDTH'(cke_ctrl_pkg::SR_EXIT_NON_READ_CLKS - 1)
                                               : TIMER_WIDTH'(cke_ctrl_pkg::PD_EXIT_TO_CMD_CLKS - 1); // R02
    wire [TIMER_WIDTH-1:0] rd_load_val =
        in_sr ? TIMER_WIDTH'(cke_ctrl_pkg::SR_EXIT_READ_CLKS - 1) :                                 // R09
        (state_reg == cke_ctrl_pkg::ST_ACT_PD) ?
            (fast_exit ? TIMER_WIDTH'(cke_ctrl_pkg::FAST_EXIT_READ_CLKS - 1)
                       : TIMER_WIDTH'(cke_ctrl_pkg::SLOW_EXIT_READ_CLKS - 1)) :                    // R03
        TIMER_WIDTH'(cke_ctrl_pkg::PD_EXIT_TO_CMD_CLKS - 1);

    delay_countdown #(.WIDTH(TIMER_WIDTH)) u_non_read_timer (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .load_in     (pd_exit || sr_exit),
        .value_in    (nr_load_val),
        .done_out    (nr_done)
    );

    delay_countdown #(.WIDTH(TIMER_WIDTH)) u_read_timer (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .load_in     (pd_exit || sr_exit),
        .value_in    (rd_load_val),
        .done_out    (rd_done)
    );

    // State transitions from previous and current enable levels plus the command.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cke_ctrl_pkg::ST_PRE_PD,
            cke_ctrl_pkg::ST_ACT_PD,
            cke_ctrl_pkg::ST_SELF_REF: begin
                if (rise) begin // R06
                    state_next = any_open ? cke_ctrl_pkg::ST_ACTIVE : cke_ctrl_pkg::ST_IDLE;
                end
            end
            default: begin
                if (fall && cmd == cke_ctrl_pkg::CMD_REFRESH && !any_open) begin
                    state_next = cke_ctrl_pkg::ST_SELF_REF; // R08
                end else if (fall) begin
                    state_next = any_open ? cke_ctrl_pkg::ST_ACT_PD : cke_ctrl_pkg::ST_PRE_PD; // R07
                end else begin
                    state_next = (banks_open_next != 4'h0) ? cke_ctrl_pkg::ST_ACTIVE : cke_ctrl_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // Bank and operation tracking; ACTIVATE, REFRESH and PRECHARGE leave no busy time.
    always_comb begin
        banks_open_next = banks_open_reg;
        busy_next       = (busy_reg != 8'h00) ? busy_reg - 8'h01 : busy_reg;
        if (ap_pending_reg && busy_reg == 8'h01) begin
            banks_open_next[ap_bank_reg] = 1'b0; // R16
        end
        if (exec_cmd) begin
            if (cmd == cke_ctrl_pkg::CMD_ACTIVATE) begin
                banks_open_next[bank] = 1'b1; // R18
            end else if (cmd == cke_ctrl_pkg::CMD_PRECHARGE) begin
                banks_open_next = addr[10] ? 4'h0 : (banks_open_reg & ~(4'h1 << bank)); // R18
            end else if (is_read) begin
                busy_next = 8'(cke_ctrl_pkg::READ_BUSY_CLKS - 1); // R14
            end else if (is_write) begin
                busy_next = 8'(cke_ctrl_pkg::WRITE_BUSY_CLKS) + {5'h00, wr_field}; // R15 R17
            end else if (cmd == cke_ctrl_pkg::CMD_LOAD_MODE) begin
                busy_next = 8'(cke_ctrl_pkg::LOAD_MODE_TO_CMD_CLKS - 1); // R19
            end
        end
    end

    // Violations seen at the pins are recorded, never acted on.
    always_comb begin
        flag_set = '0;
        flag_set[cke_ctrl_pkg::FLG_LEVEL_TIME]  = (cke_cur != cke_prev_reg) &&
                                                   (level_cnt_reg < 2'(cke_ctrl_pkg::MIN_ENABLE_LEVEL_CLKS)); // R01
        flag_set[cke_ctrl_pkg::FLG_BAD_CKE_CMD] = (fall && normal && !is_nop && cmd != cke_ctrl_pkg::CMD_REFRESH) ||
                                                   (rise && !normal && !is_nop); // R13
        flag_set[cke_ctrl_pkg::FLG_ENTRY_BUSY]  = fall && normal && !entry_ok; // R04 R12 R24
        flag_set[cke_ctrl_pkg::FLG_EXIT_WINDOW] = exec_cmd && (is_read ? !rd_done : !nr_done);
        flag_set[cke_ctrl_pkg::FLG_SR_NOT_IDLE] = fall && normal && cmd == cke_ctrl_pkg::CMD_REFRESH && any_open;
        flag_set[cke_ctrl_pkg::FLG_TERM_IN_SR]  = in_sr && term_pin; // R11
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            state_reg      <= cke_ctrl_pkg::ST_IDLE;
            banks_open_reg <= 4'h0;
            busy_reg       <= 8'h00;
            ap_pending_reg <= 1'b0;
            ap_bank_reg    <= 2'h0;
            cke_prev_reg   <= 1'b1;
            level_cnt_reg  <= 2'(cke_ctrl_pkg::MIN_ENABLE_LEVEL_CLKS);
            pd_low_cnt_reg <= 2'h0;
            mode_reg       <= cke_ctrl_pkg::MR_RESET;
        end else begin
            state_reg      <= state_next; // R25
            banks_open_reg <= banks_open_next;
            busy_reg       <= busy_next;
            cke_prev_reg   <= cke_cur; // R25
            if (cke_cur != cke_prev_reg) begin
                level_cnt_reg <= 2'h1;
            end else if (level_cnt_reg < 2'(cke_ctrl_pkg::MIN_ENABLE_LEVEL_CLKS)) begin
                level_cnt_reg <= level_cnt_reg + 2'h1;
            end
            if (!in_pre_pd) begin
                pd_low_cnt_reg <= 2'h0;
            end else if (pd_low_cnt_reg < 2'(cke_ctrl_pkg::FREQ_CHANGE_MIN_CLKS)) begin
                pd_low_cnt_reg <= pd_low_cnt_reg + 2'h1; // R20
            end
            if (exec_cmd && (is_read || is_write)) begin
                ap_pending_reg <= addr[10]; // R16
                ap_bank_reg    <= bank;
            end else if (busy_reg == 8'h01) begin
                ap_pending_reg <= 1'b0;
            end
            if (exec_cmd && cmd == cke_ctrl_pkg::CMD_LOAD_MODE && bank == 2'h0) begin
                mode_reg <= addr; // R17 R21
            end
        end
    end

    // Output flops; the low-power indications follow the state one cycle later.
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            power_down_out         <= 1'b0;
            self_refresh_out       <= 1'b0;
            buffers_off_out        <= 1'b0;
            dll_frozen_out         <= 1'b0;
            termination_active_out <= 1'b0;
            cmd_ready_out          <= 1'b0;
            read_ready_out         <= 1'b0;
            freq_change_ok_out     <= 1'b0;
        end else begin
            power_down_out         <= in_pd; // R10
            self_refresh_out       <= in_sr;
            buffers_off_out        <= in_pd || in_sr; // R23
            dll_frozen_out         <= in_pre_pd; // R23
            termination_active_out <= term_en && term_pin && !in_sr; // R11 R22
            cmd_ready_out          <= normal && nr_done; // R02
            read_ready_out         <= normal && rd_done; // R03 R05 R09
            freq_change_ok_out     <= in_pre_pd && !cke_cur && !term_pin &&
                                      (pd_low_cnt_reg >= 2'(cke_ctrl_pkg::FREQ_CHANGE_MIN_CLKS)); // R20
        end
    end

    // AHB-Lite slave: zero wait states, OKAY always, unmapped reads return zero.
    wire       ahb_take  = hsel_in && htrans_in[1] && hready_in;
    wire [7:0] ahb_ofs   = {haddr_in[7:2], 2'b00};
    logic      wr_pend_reg;
    logic [7:0] wr_ofs_reg;
    wire       wr_ctrl   = wr_pend_reg && (wr_ofs_reg == cke_ctrl_pkg::OFS_CTRL);
    wire       wr_flags  = wr_pend_reg && (wr_ofs_reg == cke_ctrl_pkg::OFS_FLAGS);
    wire [31:0] status_word = {20'h0, pd_low_cnt_reg, busy_reg != 8'h00, rd_done, nr_done,
                               banks_open_reg, state_reg};
    wire [31:0] rd_word =
        (ahb_ofs == cke_ctrl_pkg::OFS_CTRL)   ? ctrl_reg :
        (ahb_ofs == cke_ctrl_pkg::OFS_MODE)   ? {18'h0, mode_reg} :
        (ahb_ofs == cke_ctrl_pkg::OFS_STATUS) ? status_word :
        (ahb_ofs == cke_ctrl_pkg::OFS_FLAGS)  ? {26'h0, flags_reg} : 32'h0000_0000;

    assign flag_clr = wr_flags ? hwdata_in[cke_ctrl_pkg::FLG_WIDTH-1:0] : '0;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            wr_pend_reg   <= 1'b0;
            wr_ofs_reg    <= 8'h00;
            ctrl_reg      <= cke_ctrl_pkg::CTRL_RESET;
            flags_reg     <= '0;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            wr_pend_reg <= ahb_take && hwrite_in;
            wr_ofs_reg  <= ahb_ofs;
            if (ahb_take && !hwrite_in) begin
                hrdata_out <= rd_word;
            end
            if (wr_ctrl) begin
                ctrl_reg <= {31'h0, hwdata_in[cke_ctrl_pkg::CTRL_TERM_EN_BIT]};
            end
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    sequence s_pd_fall;
        normal && fall && is_nop;
    endsequence

    sequence s_sr_leave;
        in_sr && rise;
    endsequence

    a_precharge_pd_entry: assert property (s_pd_fall and !any_open |=> in_pre_pd) // R07
        else $error("idle fall with NOP did not enter precharge power-down");
    a_active_pd_entry: assert property (s_pd_fall and any_open |=> state_reg == cke_ctrl_pkg::ST_ACT_PD) // R07
        else $error("fall with open row did not enter active power-down");
    a_sr_entry_idle: assert property (normal && fall && cmd == cke_ctrl_pkg::CMD_REFRESH && !any_open |=> in_sr) // R08
        else $error("refresh with falling enable did not enter self refresh");
    a_pd_hold_low: assert property ((in_pd || in_sr) && !cke_cur |=> $stable(state_reg)) // R06
        else $error("low-power state changed while enable stayed low");
    a_level_time_flag: assert property (rise && level_cnt_reg == 2'h1 |=> flags_reg[cke_ctrl_pkg::FLG_LEVEL_TIME]) // R01
        else $error("short enable level was not flagged");
    a_fast_read_exit: assert property (state_reg == cke_ctrl_pkg::ST_ACT_PD && rise && fast_exit
                                       |=> !read_ready_out ##[1:A_READ_MAX] read_ready_out) // R03
        else $error("read readiness after fast exit out of bounds");
    a_sr_read_wait: assert property (s_sr_leave |=> !read_ready_out [*8] ##[1:A_SR_MAX] read_ready_out || !cke_cur) // R09
        else $error("read readiness after self refresh exit out of bounds");
    a_buffers_follow: assert property (buffers_off_out == $past(in_pd || in_sr)) // R23
        else $error("buffer disable does not track power-down");
    a_freq_window: assert property (freq_change_ok_out |-> $past(in_pre_pd) && $past(pd_low_cnt_reg) == 2'h2) // R20
        else $error("frequency change allowed too early");
    a_busy_entry_flag: assert property (normal && fall && busy_reg != 8'h00 |=> flags_reg[cke_ctrl_pkg::FLG_ENTRY_BUSY]) // R12
        else $error("entry during operation was not flagged");

endmodule : cke_power_ctrl

// ---- tb/mem_ctrl_model.sv ----
// Memory controller model that drives clock enable, commands and termination.
`timescale 1ns/100ps
module mem_ctrl_model (
    // Clock.
    input  wire logic        core_clk_in,
    // Memory pins.
    output      logic        cke_out,
    output      logic        cs_n_out,
    output      logic        ras_n_out,
    output      logic        cas_n_out,
    output      logic        we_n_out,
    output      logic [1:0]  ba_out,
    output      logic [13:0] addr_out,
    output      logic        term_out
);
    logic [3:0] cmd_reg = cke_ctrl_pkg::CMD_NOP;
    assign {cs_n_out, ras_n_out, cas_n_out, we_n_out} = cmd_reg;
    initial begin
        cke_out = 1'b1;
        ba_out = 2'h0;
        addr_out = 14'h0;
        term_out = 1'b0;
    end
    // Sends one command, then NOPs with an inverted address so stale pins carry nothing useful.
    task automatic issue(input logic [3:0] cmd, input logic cke, input logic [1:0] ba, input logic [13:0] addr,
                         input logic term);
        @(posedge core_clk_in);
        cmd_reg <= cmd;
        cke_out <= cke;
        ba_out <= ba;
        addr_out <= addr;
        term_out <= term;
        @(posedge core_clk_in);
        cmd_reg <= cke_ctrl_pkg::CMD_NOP;
        addr_out <= ~addr;
        repeat (cke_ctrl_pkg::MIN_ENABLE_LEVEL_CLKS) @(posedge core_clk_in);
    endtask : issue
endmodule : mem_ctrl_model

// ---- tb/sdram_power_down_cke_control_test.sv ----
// Self-checking bench for the clock-enable power-state logic.
`timescale 1ns/100ps
module sdram_power_down_cke_control_test;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hrdy, hresp, cke, cs_n, ras_n, cas_n, we_n, term;
    logic [1:0]  ba;
    logic [13:0] addr;
    logic        pd, sr, boff, dfz, tact, crdy, rrdy, fok;
    int          fails = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    always #2 clk = ~clk;
    mem_ctrl_model mem_ctrl_model_i (.core_clk_in(clk), .cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n),
        .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba), .addr_out(addr), .term_out(term));
    cke_power_ctrl cke_power_ctrl_i (.core_clk_in(clk), .srst_in(srst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
        .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .cke_in(cke), .cs_n_in(cs_n),
        .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba), .addr_in(addr),
        .termination_control_in(term), .power_down_out(pd), .self_refresh_out(sr), .buffers_off_out(boff),
        .dll_frozen_out(dfz), .termination_active_out(tact), .cmd_ready_out(crdy), .read_ready_out(rrdy),
        .freq_change_ok_out(fok));
    task automatic close_out;
        $display("Mismatches %0d of %0d checks", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
        chk(hresp, 1'b0);
    endtask : bus
    task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r & m, exp);
    endtask : rd
    // Counts cycles without non-READ and READ permission from the exit edge onward.
    // Two synchroniser stages and the output flop put three edges before any permission shows.
    task automatic exit_gap(input int ncmd, input int gap);
        int nc;
        int nr;
        nc = 0;
        nr = 0;
        fork
            mem_ctrl_model_i.issue(cke_ctrl_pkg::CMD_NOP, 1'b1, 2'h0, 14'h0, 1'b0);
            repeat (400) begin
                @(posedge clk);
                #1;
                nc += int'(crdy !== 1'b1);
                nr += int'(rrdy !== 1'b1);
            end
        join
        chk(32'(nc), 32'(ncmd + 3));
        chk(32'(nr - nc), 32'(gap));
    endtask : exit_gap
    task automatic enter_pd(input logic [3:0] cmd, input logic [1:0] b, input logic t);
        mem_ctrl_model_i.issue(cmd, 1'b0, b, 14'h0, t);
        repeat (6) @(posedge clk);
    endtask : enter_pd
    initial begin
        logic [31:0] r;
        logic [3:0]  open;
        logic [1:0]  b;
        void'($urandom(89610));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) if (i != 2) rd(4 * i, 32'hffff_ffff, 32'h0);
        rd(32'h8, 32'h7f, 32'h0);
        for (int n = 0; n < 5; n++) begin
            open = 4'h0;
            repeat ($urandom % 3) begin
                b = 2'($urandom % 4);
                mem_ctrl_model_i.issue(cke_ctrl_pkg::CMD_ACTIVATE, 1'b1, b, 14'($urandom), 1'b0);
                open[b] = 1'b1;
            end
            rd(32'h8, 32'h78, {25'h0, open, 3'h0});
            enter_pd(cke_ctrl_pkg::CMD_NOP, 2'h0, 1'b0);
            chk({pd, boff, dfz, fok}, {2'b11, open == 4'h0, open == 4'h0});
            rd(32'h8, 32'h7, (open == 4'h0) ? 32'h2 : 32'h3);
            exit_gap(cke_ctrl_pkg::PD_EXIT_TO_CMD_CLKS, 0);
            mem_ctrl_model_i.issue(cke_ctrl_pkg::CMD_PRECHARGE, 1'b1, 2'h0, 14'h0400, 1'b0);
        end
        mem_ctrl_model_i.issue(cke_ctrl_pkg::CMD_LOAD_MODE, 1'b1, 2'h0, 14'h1600, 1'b0);
        rd(32'h4, 32'h3fff, 32'h1600);
        mem_ctrl_model_i.issue(cke_ctrl_pkg::CMD_ACTIVATE, 1'b1, 2'h1, 14'h0, 1'b0);
        enter_pd(cke_ctrl_pkg::CMD_NOP, 2'h0, 1'b0);
        exit_gap(cke_ctrl_pkg::PD_EXIT_TO_CMD_CLKS,
                 cke_ctrl_pkg::SLOW_EXIT_READ_CLKS - cke_ctrl_pkg::PD_EXIT_TO_CMD_CLKS);
        mem_ctrl_model_i.issue(cke_ctrl_pkg::CMD_PRECHARGE, 1'b1, 2'h0, 14'h0400, 1'b0);
        bus(1'b1, 32'h0, 32'h1, r);
        rd(32'h0, 32'hffff_ffff, 32'h1);
        enter_pd(cke_ctrl_pkg::CMD_REFRESH, 2'h0, 1'b1);
        chk({sr, boff, tact}, 3'b110);
        mem_ctrl_model_i.issue(cke_ctrl_pkg::CMD_NOP, 1'b0, 2'h0, 14'h0, 1'b0);
        rd(32'hc, 32'hffff_ffff, 32'h20);
        bus(1'b1, 32'hc, 32'h20, r);
        rd(32'hc, 32'hffff_ffff, 32'h0);
        exit_gap(cke_ctrl_pkg::SR_EXIT_NON_READ_CLKS,
                 cke_ctrl_pkg::SR_EXIT_READ_CLKS - cke_ctrl_pkg::SR_EXIT_NON_READ_CLKS);
        mem_ctrl_model_i.issue(cke_ctrl_pkg::CMD_NOP, 1'b1, 2'h0, 14'h0, 1'b1);
        repeat (6) @(posedge clk);
        chk({sr, tact}, 2'b01);
        enter_pd(cke_ctrl_pkg::CMD_ACTIVATE, 2'h2, 1'b0);
        chk(pd, 1'b1);
        rd(32'hc, 32'hffff_ffff, 32'h2);
        // Entry during a write burst is deliberate: the flag must catch it while auto precharge still closes the bank.
        mem_ctrl_model_i.issue(cke_ctrl_pkg::CMD_NOP, 1'b1, 2'h0, 14'h0, 1'b0);
        mem_ctrl_model_i.issue(cke_ctrl_pkg::CMD_ACTIVATE, 1'b1, 2'h3, 14'h0, 1'b0);
        mem_ctrl_model_i.issue(cke_ctrl_pkg::CMD_WRITE, 1'b1, 2'h3, 14'h0400, 1'b0);
        enter_pd(cke_ctrl_pkg::CMD_NOP, 2'h0, 1'b0);
        rd(32'h8, 32'h27f, 32'h3);
        rd(32'hc, 32'hffff_ffff, 32'h6);
        close_out();
    end
endmodule : sdram_power_down_cke_control_test
